// [acc_pkg.sv]
// Constants and carrier types for the analog comparator control block.
package acc_pkg;
   localparam logic [7:0] OFS_IRQ_EN = 8'h00;
   localparam logic [7:0] OFS_IRQ_ST = 8'h04;
   localparam logic [7:0] OFS_LOCK   = 8'h0C;
   localparam logic [7:0] OFS_CTRL   = 8'h10;
   localparam logic [7:0] OFS_FILC   = 8'h14;
   localparam logic [7:0] OFS_FILP   = 8'h18;
   localparam int         CTRL_OUT_BIT = 17;
   localparam logic [15:0] FILP_RST  = 16'h0000;
   // Trigger route codes.
   localparam logic [2:0] TRG_NONE    = 3'h0;
   localparam logic [2:0] TRG_A_BREAK = 3'h1;
   localparam logic [2:0] TRG_A_CAP1  = 3'h2;
   localparam logic [2:0] TRG_A_RCLR  = 3'h3;
   localparam logic [2:0] TRG_B_CAP1  = 3'h4;
   localparam logic [2:0] TRG_B_RCLR  = 3'h5;
   localparam int         TRG_LINES   = 5;

   // Control register layout, bit 14 down to bit 0.
   typedef struct packed {
      logic       blanking_select;
      logic [1:0] hysteresis_level;
      logic       output_polarity;
      logic       rsv10;
      logic [2:0] trigger_route_select;
      logic [1:0] rsv6;
      logic [1:0] reference_offset_select;
      logic       positive_input_select;
      logic       negative_input_select;
      logic       enable;
   } acc_ctrl_t;

   // Filter control layout, bit 10 down to bit 0.
   typedef struct packed {
      logic [4:0] filter_window_size;
      logic [4:0] filter_threshold;
      logic       filter_enable;
   } acc_filt_t;

   localparam acc_ctrl_t CTRL_RST = '0;
   localparam acc_filt_t FILT_RST = '0;
endpackage : acc_pkg

// [acc_comparator_ctrl.sv]
// Digital control around one analog comparator, with its APB register slave.
// Summary of operation
// - Raw result is high when positive input exceeds negative input.
// - Two-bit field selects 300, 200, 100 or 0 mV positive offset.
// - Polarity bit inverts the output seen by status, pin and triggers.
// - Two-bit hysteresis field selects none, low, medium or high.
// - Positive-input select bit picks first or second pin option.
// - Negative-input select bit picks first or second pin option.
// - Three-bit route field sends output to one timer input or none.
// - With blanking select set, an asserted blanking source forces the output inactive.
// - Filter has window, threshold, sampling rate and enable, all programmable.
// - Once set, the lock stays set until reset.
// - Result goes to a port pin and to timer trigger inputs.
// - Non-inverted: interrupt when status rises because positive exceeds negative.
// - Inverted: interrupt when status rises because positive is below negative.
// - Registers are an APB slave.
// - Lock makes control, filter control and prescaler registers read-only.
// - Writing 0 to the interrupt flag clears it.
// - Blanking select 1 uses timer A fifth compare as blanking source.
module acc_comparator_ctrl (
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     psel_in,
   input  wire logic                     penable_in,
   input  wire logic                     pwrite_in,
   input  wire logic [7:0]               paddr_in,
   input  wire logic [31:0]              pwdata_in,
   output logic      [31:0]              prdata_out,
   output logic                          pready_out,
   output logic                          pslverr_out,
   input  wire logic                     raw_result_in,
   input  wire logic                     blank_source_in,
   output acc_pkg::acc_ctrl_t            analog_ctrl_out,
   output logic                          port_pin_out,
   output logic [acc_pkg::TRG_LINES-1:0] trigger_output_out,
   output logic                          irq_out
);
   import acc_pkg::*;

   // Counts the ones among the newest n+1 samples.
   function automatic logic [5:0] ones_in_window(input logic [31:0] h, input logic [4:0] n);
      logic [5:0] c;
      c = '0;
      for (int i = 0; i < 32; i++) begin
         if (i <= int'(n) && h[i]) begin
            c = c + 6'h01;
         end
      end
      return c;
   endfunction : ones_in_window

   acc_ctrl_t   ctrl_q, ctrl_d;
   acc_filt_t   filt_q, filt_d;
   logic [15:0] psc_q, psc_d;
   logic        inten_q, inten_d;
   logic        flag_q, flag_d;
   logic        lock_q, lock_d;
   logic [31:0] rdata_q, rdata_d;
   logic        ready_q, ready_d;
   logic        err_q, err_d;
   logic        sync1_q, sync2_q;
   logic [15:0] div_q, div_d;
   logic [31:0] hist_q, hist_d;
   logic        lvl_q, lvl_d;
   logic        out_q, out_d;
   logic        pin_q, pin_d;
   logic [TRG_LINES-1:0] trg_q, trg_d;
   logic        irq_q, irq_d;
   logic        acc, wr, mapped, tick;
   logic [5:0]  ones, zeros, thr;

   // The analog result is asynchronous; two flops before anything reads it.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= raw_result_in;
         sync2_q <= sync1_q;
      end
   end

   // Register slave: one wait state, so every answer comes from a flop.
   always_comb begin
      acc     = psel_in && penable_in && ready_q;
      wr      = acc && pwrite_in;
      ready_d = psel_in && penable_in && !ready_q;
      mapped  = 1'b1;
      rdata_d = '0;
      if (paddr_in == OFS_IRQ_EN) begin
         rdata_d[0] = inten_q;
      end else if (paddr_in == OFS_IRQ_ST) begin
         rdata_d[0] = flag_q;
      end else if (paddr_in == OFS_LOCK) begin
         rdata_d[0] = lock_q;
      end else if (paddr_in == OFS_CTRL) begin
         rdata_d[$bits(acc_ctrl_t)-1:0] = ctrl_q;
         rdata_d[CTRL_OUT_BIT]          = out_q;
      end else if (paddr_in == OFS_FILC) begin
         rdata_d[$bits(acc_filt_t)-1:0] = filt_q;
      end else if (paddr_in == OFS_FILP) begin
         rdata_d[15:0] = psc_q;
      end else begin
         mapped = 1'b0;
      end
      if (!ready_d) begin
         rdata_d = rdata_q;
      end
      err_d = ready_d && !mapped;
   end

   // Register writes; locked registers silently keep their contents.
   always_comb begin
      inten_d = inten_q;
      lock_d  = lock_q;
      ctrl_d  = ctrl_q;
      filt_d  = filt_q;
      psc_d   = psc_q;
      if (wr && paddr_in == OFS_IRQ_EN) begin
         inten_d = pwdata_in[0];
      end
      if (wr && paddr_in == OFS_LOCK && pwdata_in[0]) begin
         lock_d = 1'b1;
      end
      if (wr && !lock_q) begin
         if (paddr_in == OFS_CTRL) begin
            ctrl_d      = acc_ctrl_t'(pwdata_in[$bits(acc_ctrl_t)-1:0]);
            ctrl_d.rsv10 = 1'b0;
            ctrl_d.rsv6  = 2'h0;
         end else if (paddr_in == OFS_FILC) begin
            filt_d = acc_filt_t'(pwdata_in[$bits(acc_filt_t)-1:0]);
         end else if (paddr_in == OFS_FILP) begin
            psc_d = pwdata_in[15:0];
         end
      end
   end

   // Filter: sample every psc+1 clocks, vote over the window.
   always_comb begin
      tick   = (div_q == psc_q);
      div_d  = tick ? 16'h0000 : div_q + 16'h0001;
      hist_d = tick ? {hist_q[30:0], sync2_q} : hist_q;
      ones   = ones_in_window(hist_q, filt_q.filter_window_size);
      zeros  = {1'b0, filt_q.filter_window_size} + 6'h01 - ones;
      thr    = (filt_q.filter_threshold == 5'h00) ? 6'h01 : {1'b0, filt_q.filter_threshold};
      lvl_d  = lvl_q;
      if (!filt_q.filter_enable) begin
         lvl_d = sync2_q;
      end else if (ones >= thr && zeros < thr) begin
         lvl_d = 1'b1;
      end else if (zeros >= thr && ones < thr) begin
         lvl_d = 1'b0;
      end
   end

   // Output path: polarity, then blanking, then routing and the interrupt flag.
   always_comb begin
      out_d = ctrl_q.enable && (lvl_q ^ ctrl_q.output_polarity);
      if (ctrl_q.blanking_select && blank_source_in) begin
         out_d = 1'b0;
      end
      pin_d = out_d;
      for (int i = 0; i < TRG_LINES; i++) begin
         trg_d[i] = out_d && (ctrl_q.trigger_route_select == 3'(i + 1));
      end
      flag_d = flag_q;
      if (wr && paddr_in == OFS_IRQ_ST && !pwdata_in[0]) begin
         flag_d = 1'b0;
      end
      if (out_d && !out_q) begin
         flag_d = 1'b1;
      end
      irq_d = flag_d && inten_d;
   end

   // State registers, reset to their documented values.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_q  <= CTRL_RST;
         filt_q  <= FILT_RST;
         psc_q   <= FILP_RST;
         inten_q <= 1'b0;
         flag_q  <= 1'b0;
         lock_q  <= 1'b0;
         rdata_q <= '0;
         ready_q <= 1'b0;
         err_q   <= 1'b0;
         div_q   <= '0;
         hist_q  <= '0;
         lvl_q   <= 1'b0;
         out_q   <= 1'b0;
         pin_q   <= 1'b0;
         trg_q   <= '0;
         irq_q   <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         filt_q  <= filt_d;
         psc_q   <= psc_d;
         inten_q <= inten_d;
         flag_q  <= flag_d;
         lock_q  <= lock_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q   <= err_d;
         div_q   <= div_d;
         hist_q  <= hist_d;
         lvl_q   <= lvl_d;
         out_q   <= out_d;
         pin_q   <= pin_d;
         trg_q   <= trg_d;
         irq_q   <= irq_d;
      end
   end

   assign prdata_out         = rdata_q;
   assign pready_out         = ready_q;
   assign pslverr_out        = err_q;
   assign analog_ctrl_out    = ctrl_q;
   assign port_pin_out       = pin_q;
   assign trigger_output_out = trg_q;
   assign irq_out            = irq_q;

   // Checks on the behaviour above.
   chk_lock_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      lock_q |=> lock_q) else $error("lock bit dropped");
   chk_lock_ctrl_frozen: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      lock_q |=> $stable(ctrl_q) && $stable(filt_q) && $stable(psc_q)) else $error("locked register changed");
   chk_flag_on_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(out_q) |-> flag_q) else $error("flag not set on output rise");
   chk_flag_clear_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr && paddr_in == OFS_IRQ_ST && !pwdata_in[0] && !out_d) |=> !flag_q) else $error("flag not cleared");
   chk_irq_gating: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      irq_q == (flag_q && inten_q)) else $error("interrupt not flag and enable");
   chk_blank_forces_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ctrl_q.blanking_select && blank_source_in) |=> !out_q && trg_q == '0) else $error("blanking ignored");
   chk_route_onehot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $onehot0(trg_q) && (trg_q == '0 || pin_q)) else $error("trigger routing wrong");
   chk_apb_one_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (psel_in && !penable_in) ##1 (psel_in && penable_in) |=> pready_out ##1 !pready_out)
      else $error("answer timing wrong");
   chk_polarity_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ctrl_q.enable && !ctrl_q.blanking_select && $stable(ctrl_q)) |=> out_q == ($past(lvl_q) ^ $past(ctrl_q.output_polarity)))
      else $error("polarity path wrong");

   // Output path: an unfiltered level follows the synchroniser, and the pin mirrors the output.
   chk_sync_passthru: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !filt_q.filter_enable |=> lvl_q == $past(sync2_q))
      else $error("unfiltered level lost the input");
   chk_out_disabled: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !ctrl_q.enable |=> !out_q)
      else $error("disabled comparator drove output");
   chk_pin_follows_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pin_q == out_q)
      else $error("pin differs from output");

   // Routing: each code reaches only its own line, and unused codes reach none.
   chk_route_none: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ctrl_q.trigger_route_select == TRG_NONE) |=> trg_q == '0)
      else $error("route none drove a trigger");
   chk_route_reserved: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ctrl_q.trigger_route_select > TRG_B_RCLR) |=> trg_q == '0)
      else $error("reserved route drove a trigger");
   chk_route_break: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ctrl_q.trigger_route_select == TRG_A_BREAK) |=> trg_q[0] == out_q)
      else $error("break line differs from output");
   chk_route_ref_b: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ctrl_q.trigger_route_select == TRG_B_RCLR) |=> trg_q[4] == out_q)
      else $error("second timer clear line differs from output");

   // Filter: a split vote holds the level, and a minority never moves it.
   chk_filter_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (filt_q.filter_enable && ones < thr && zeros < thr) |=> $stable(lvl_q))
      else $error("filter moved on a split vote");
   chk_filter_no_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (filt_q.filter_enable && !lvl_q && ones < thr) |=> !lvl_q)
      else $error("filter rose without enough ones");
   chk_filter_no_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (filt_q.filter_enable && lvl_q && zeros < thr) |=> lvl_q)
      else $error("filter fell without enough zeros");
   chk_sample_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (div_q != psc_q) |=> $stable(hist_q))
      else $error("history shifted between sample ticks");

   // Register slave: single-cycle answers, error only on unmapped offsets, sticky flags.
   chk_ready_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pready_out |=> !pready_out)
      else $error("ready held longer than one cycle");
   chk_err_with_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pslverr_out |-> pready_out)
      else $error("error without ready");
   chk_unmapped_err: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (psel_in && penable_in && !ready_q && !mapped) |=> pslverr_out)
      else $error("unmapped offset not flagged");
   chk_lock_on_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr && paddr_in == OFS_LOCK && pwdata_in[0]) |=> lock_q)
      else $error("lock write not taken");
   chk_flag_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (flag_q && !(wr && paddr_in == OFS_IRQ_ST && !pwdata_in[0])) |=> flag_q)
      else $error("flag dropped without a clear");
   chk_filp_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr && !lock_q && paddr_in == OFS_FILP) |=> psc_q == $past(pwdata_in[15:0]))
      else $error("unlocked prescaler write lost");
endmodule : acc_comparator_ctrl

// [acc_analog_model.sv]
// Behavioural analog core: pin voltages in, raw comparison out.
module acc_analog_model
   import acc_pkg::*;
(
   input  wire acc_pkg::acc_ctrl_t ctrl_in,
   input  var  int                 p0_in,
   input  var  int                 p1_in,
   input  var  int                 n0_in,
   input  var  int                 n1_in,
   output logic                    raw_out
);
   int pos_mv;
   int neg_mv;

   // Offset code order is an assumption: code 0 subtracts nothing, so benches keep it at 0.
   always_comb begin
      pos_mv = (ctrl_in.positive_input_select ? p1_in : p0_in);
      pos_mv = pos_mv - 100 * int'(ctrl_in.reference_offset_select);
      neg_mv = (ctrl_in.negative_input_select ? n1_in : n0_in);
      raw_out = (pos_mv > neg_mv);
   end
endmodule : acc_analog_model

// [acc_comparator_ctrl_tb.sv]
// Self-checking bench for the comparator control block.
`define CHECK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module acc_comparator_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import acc_pkg::*;
   logic        clk_in, rst_n_in, psel, pen, pwr, pready, pslverr, raw, blank, pin, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [4:0]  trg;
   acc_ctrl_t   ctrl, c;
   int          p0, p1, n0, n1, err_count, checks_done, cyc;

   acc_comparator_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .raw_result_in(raw), .blank_source_in(blank), .analog_ctrl_out(ctrl),
      .port_pin_out(pin), .trigger_output_out(trg), .irq_out(irq));
   acc_analog_model core (.ctrl_in(ctrl), .p0_in(p0), .p1_in(p1), .n0_in(n0), .n1_in(n1), .raw_out(raw));

   // Holds the request until ready is seen high at a rising edge, takes the answer there, then releases.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      rd_q = prdata;
      `CHECK("slverr", a == 8'h08, pslverr)
      psel <= 1'b0; pen <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHECK("rdata", e, rd_q)
   endtask : rd

   // Sets the first positive and negative pin voltages (p0, n0) and waits out the synchroniser and output flops.
   task automatic lvl(input int p, input int n);
      p0 <= p; n0 <= n;
      repeat (10) @(posedge clk_in);
   endtask : lvl

   task automatic t_regs;
      rd(OFS_IRQ_EN, 32'h0);
      rd(OFS_IRQ_ST, 32'h0);
      rd(OFS_LOCK, 32'h0);
      rd(8'h08, 32'h0);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_route;
      c = CTRL_RST;
      c.enable = 1'b1;
      c.hysteresis_level = 2'h3;
      lvl(600, 400);
      for (int k = 0; k < 8; k++) begin
         c.trigger_route_select = 3'(k);
         apb(1'b1, OFS_CTRL, {17'h0, c}); lvl(600, 400);
         `CHECK("pin", 1'b1, pin)
         `CHECK("trg", (k inside {[1:5]}) ? 5'(1 << (k - 1)) : 5'h00, trg)
      end
      rd(OFS_CTRL, 32'h0002_0000 | {17'h0, c});
      c.trigger_route_select = TRG_A_BREAK; c.output_polarity = 1'b1;
      apb(1'b1, OFS_CTRL, {17'h0, c}); lvl(600, 400);
      `CHECK("pol", 5'h00, {trg[4:1], pin})
      c.positive_input_select = 1'b1; p1 <= 0;
      apb(1'b1, OFS_CTRL, {17'h0, c}); lvl(600, 400);
      `CHECK("sel", 2'b11, {trg[0], pin})
      c.negative_input_select = 1'b1; n1 <= -100;
      apb(1'b1, OFS_CTRL, {17'h0, c}); lvl(600, 400);
      `CHECK("sel", 2'b00, {trg[0], pin})
      $display("t_route done");
   endtask : t_route

   task automatic t_irq;
      c = CTRL_RST; c.enable = 1'b1;
      apb(1'b1, OFS_CTRL, {17'h0, c}); lvl(200, 400);
      apb(1'b1, OFS_IRQ_EN, 32'h1); apb(1'b1, OFS_IRQ_ST, 32'h0);
      @(posedge clk_in);
      `CHECK("irq", 1'b0, irq)
      lvl(600, 400);
      `CHECK("irq", 1'b1, irq)
      rd(OFS_IRQ_ST, 32'h1);
      apb(1'b1, OFS_IRQ_ST, 32'h0); lvl(600, 400);
      `CHECK("irq", 1'b0, irq)
      c.output_polarity = 1'b1;
      apb(1'b1, OFS_CTRL, {17'h0, c}); apb(1'b1, OFS_IRQ_ST, 32'h0); lvl(200, 400);
      `CHECK("irq", 1'b1, irq)
      $display("t_irq done");
   endtask : t_irq

   task automatic t_blank;
      c = CTRL_RST; c.enable = 1'b1; c.blanking_select = 1'b1;
      apb(1'b1, OFS_CTRL, {17'h0, c}); blank <= 1'b1; lvl(600, 400);
      `CHECK("blank", 1'b0, pin)
      blank <= 1'b0; lvl(600, 400);
      `CHECK("blank", 1'b1, pin)
      c.blanking_select = 1'b0;
      apb(1'b1, OFS_CTRL, {17'h0, c}); blank <= 1'b1; lvl(600, 400);
      `CHECK("blank", 1'b1, pin)
      $display("t_blank done");
   endtask : t_blank

   // Window of four samples with threshold three: a one-sample dip must not pass.
   task automatic t_filt;
      c.enable = 1'b0;
      apb(1'b1, OFS_CTRL, {17'h0, c});
      apb(1'b1, OFS_FILP, 32'h1);
      apb(1'b1, OFS_FILC, 32'h0000_00C7);
      c.enable = 1'b1;
      apb(1'b1, OFS_CTRL, {17'h0, c}); lvl(600, 400);
      `CHECK("filt", 1'b1, pin)
      p0 <= 200;
      @(posedge clk_in);
      p0 <= 600;
      repeat (10) begin
         @(posedge clk_in);
         `CHECK("dip", 1'b1, pin)
      end
      lvl(200, 400); lvl(200, 400);
      `CHECK("filt", 1'b0, pin)
      $display("t_filt done");
   endtask : t_filt

   task automatic t_lock;
      apb(1'b1, OFS_LOCK, 32'h1); apb(1'b1, OFS_LOCK, 32'h0);
      rd(OFS_LOCK, 32'h1);
      apb(1'b1, OFS_CTRL, 32'h0); apb(1'b1, OFS_FILC, 32'h0);
      `CHECK("ctrl", c, ctrl)
      rd(OFS_FILC, 32'h0000_00C7);
      apb(1'b1, OFS_FILP, 32'h5);
      rd(OFS_FILP, 32'h1);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(OFS_LOCK, 32'h0);
      `CHECK("ctrl", CTRL_RST, ctrl)
      apb(1'b1, OFS_CTRL, {17'h0, c});
      @(posedge clk_in);
      `CHECK("ctrl", c, ctrl)
      $display("t_lock done");
   endtask : t_lock

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // A hang ends the run after far more cycles than the tests need.
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end

   initial begin
      {rst_n_in, psel, pen, pwr, blank, paddr, pwdata} = '0;
      {p0, p1, n0, n1} = {32'd0, 32'd0, 32'd400, 32'd400};
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_regs();
      t_route();
      t_irq();
      t_blank();
      t_filt();
      t_lock();
      wrap_up();
   end
endmodule : acc_comparator_ctrl_tb
